// ---- yuvpk_pkg.sv ----
// Constants and types shared by the 4:2:2 byte packer
package yuvpk_pkg;

	localparam int PIX_W       = 8;
	localparam int BYTE_W      = 8;
	localparam int PAIR_BYTES  = 4;
	localparam int WORD_W      = PAIR_BYTES * BYTE_W + 1;
	localparam int FIFO_DEPTH  = 8;
	localparam int FIFO_AW     = 3;
	localparam int SUM_W       = 18;

	// Luma weights, sum of 256
	localparam logic signed [SUM_W-1:0] Y_R = 18'sh0004d;
	localparam logic signed [SUM_W-1:0] Y_G = 18'sh00096;
	localparam logic signed [SUM_W-1:0] Y_B = 18'sh0001d;
	// Chroma weights, each row sums to zero
	localparam logic signed [SUM_W-1:0] U_R = -18'sh0002b;
	localparam logic signed [SUM_W-1:0] U_G = -18'sh00055;
	localparam logic signed [SUM_W-1:0] U_B = 18'sh00080;
	localparam logic signed [SUM_W-1:0] V_R = 18'sh00080;
	localparam logic signed [SUM_W-1:0] V_G = -18'sh0006b;
	localparam logic signed [SUM_W-1:0] V_B = -18'sh00015;
	localparam logic signed [SUM_W-1:0] Y_RND = 18'sh00080;
	localparam int SUM_SHIFT = 8;

	localparam logic [BYTE_W-1:0] CHROMA_OFS = 8'h80;
	localparam logic [1:0] LAST_IDX = 2'h3;

	typedef enum logic {
		FMT_UYVY = 1'b0,
		FMT_YUYV = 1'b1
	} yuvpk_fmt_type;

endpackage

// ---- yuvpk_packer.sv ----
// 4:2:2 byte packer: colour conversion, pair assembly, FIFO, serializer
// How it works
// (R01) Every incoming RGB pixel passes a colour conversion stage into Y, U, V before packing.
// (R02) Signed U and V get 128 added so that -128..+127 leaves as 0..255.
// (R03) In UYVY order each pair leaves as U even, Y even, V even, Y odd.
// (R04) In YUYV order each pair leaves as Y even, U even, Y odd, V even.
// (R05) Luma goes out for every paired pixel, chroma only from the even pixel of a pair.
// (R06) Both orders carry identical byte contents and differ only in order.
// (R07) Luma is an unsigned byte, 0x00 is level 0 and 0xff is level 255.
// (R08) Chroma is offset binary, 0x80 is zero, 0xff is +127, 0x00 is -128.
// (R09) An unpaired last pixel of an odd-length line is dropped, and the first byte out is the first pixel's.
`timescale 1ns/100ps

module yuvpk_fifo
	import yuvpk_pkg::*;
#(
	parameter int WIDTH = WORD_W,
	parameter int DEPTH = FIFO_DEPTH,
	parameter int AW    = FIFO_AW
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;
	logic             full;
	logic             empty;

	// Count is one bit wider than the pointers so full and empty differ
	assign full      = (count_reg == (AW+1)'(DEPTH));
	assign empty     = (count_reg == '0);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 :
					wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 :
					rd_ptr_reg + AW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else if (push && !pop) begin
			count_reg <= count_reg + (AW+1)'(1);
		end else if (pop && !push) begin
			count_reg <= count_reg - (AW+1)'(1);
		end
	end

endmodule // yuvpk_fifo

module yuvpk_packer
	import yuvpk_pkg::*;
(
	input  wire logic              MCLK,
	input  wire logic              RST_N,
	input  wire logic              FMT_SEL,
	input  wire logic              PIX_VALID,
	output logic                   PIX_READY,
	input  wire logic              PIX_FIRST,
	input  wire logic [PIX_W-1:0]  PIX_RED,
	input  wire logic [PIX_W-1:0]  PIX_GREEN,
	input  wire logic [PIX_W-1:0]  PIX_BLUE,
	output logic                   BYTE_VALID,
	input  wire logic              BYTE_READY,
	output logic      [BYTE_W-1:0] BYTE_DATA,
	output logic                   BYTE_FIRST,
	output logic                   BYTE_LAST
);

	logic                    rst_s1_reg;
	logic                    rst_n_sync;
	logic                    fmt_s1_reg;
	logic                    fmt_s2_reg;
	logic                    fmt_s3_reg;
	yuvpk_fmt_type           fmt_reg;

	logic signed [SUM_W-1:0] r_s;
	logic signed [SUM_W-1:0] g_s;
	logic signed [SUM_W-1:0] b_s;
	logic signed [SUM_W-1:0] y_sum;
	logic signed [SUM_W-1:0] u_sum;
	logic signed [SUM_W-1:0] v_sum;
	logic                    pix_take;

	logic                    c_vld_reg;
	logic                    c_first_reg;
	logic [BYTE_W-1:0]       c_y_reg;
	logic [BYTE_W-1:0]       c_u_reg;
	logic [BYTE_W-1:0]       c_v_reg;
	logic                    c_take;
	logic                    c_odd;

	logic                    odd_reg;
	logic                    e_first_reg;
	logic [BYTE_W-1:0]       e_y_reg;
	logic [BYTE_W-1:0]       e_u_reg;
	logic [BYTE_W-1:0]       e_v_reg;

	logic                    f_in_valid;
	logic                    f_in_ready;
	logic [WORD_W-1:0]       f_in_data;
	logic                    f_out_valid;
	logic                    f_out_ready;
	logic [WORD_W-1:0]       f_out_data;

	logic [1:0]              idx_reg;
	logic                    load;
	logic [BYTE_W-1:0]       byte_sel;

	// Reset release through two flops
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_s1_reg <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_sync <= rst_s1_reg;
		end
	end

	// Format pin: three flops, taken when stages two and three agree
	always_ff @(posedge MCLK or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			fmt_s1_reg <= 1'b0;
			fmt_s2_reg <= 1'b0;
			fmt_s3_reg <= 1'b0;
			fmt_reg    <= FMT_UYVY;
		end else begin
			fmt_s1_reg <= FMT_SEL;
			fmt_s2_reg <= fmt_s1_reg;
			fmt_s3_reg <= fmt_s2_reg;
			if (fmt_s2_reg == fmt_s3_reg) begin
				fmt_reg <= yuvpk_fmt_type'(fmt_s3_reg);
			end
		end
	end

	// Colour conversion, luma rounded and chroma floored by arithmetic shift
	always_comb begin
		r_s   = $signed({10'h000, PIX_RED});
		g_s   = $signed({10'h000, PIX_GREEN});
		b_s   = $signed({10'h000, PIX_BLUE});
		y_sum = (Y_R * r_s + Y_G * g_s + Y_B * b_s + Y_RND) >>> SUM_SHIFT; // R01
		u_sum = (U_R * r_s + U_G * g_s + U_B * b_s) >>> SUM_SHIFT; // R01
		v_sum = (V_R * r_s + V_G * g_s + V_B * b_s) >>> SUM_SHIFT; // R01
	end

	assign pix_take  = PIX_VALID & PIX_READY;
	// Pixel refused only while an odd pixel waits on a full FIFO
	assign PIX_READY = !c_vld_reg | c_take;

	// Stage occupancy
	always_ff @(posedge MCLK or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			c_vld_reg <= 1'b0;
		end else if (pix_take) begin
			c_vld_reg <= 1'b1;
		end else if (c_take) begin
			c_vld_reg <= 1'b0;
		end
	end

	// Converted pixel, offset applied to chroma
	always_ff @(posedge MCLK or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			c_first_reg <= 1'b0;
			c_y_reg     <= '0;
			c_u_reg     <= CHROMA_OFS;
			c_v_reg     <= CHROMA_OFS;
		end else if (pix_take) begin
			c_first_reg <= PIX_FIRST;
			c_y_reg     <= y_sum[BYTE_W-1:0]; // R07
			c_u_reg     <= u_sum[BYTE_W-1:0] + CHROMA_OFS; // R02 R08
			c_v_reg     <= v_sum[BYTE_W-1:0] + CHROMA_OFS; // R02 R08
		end
	end

	// Line start forces the pixel to the even slot
	assign c_odd  = odd_reg & !c_first_reg; // R09
	assign c_take = c_vld_reg & (!c_odd | f_in_ready);

	// Pair slot set after an even pixel, cleared after an odd one taken from the stage
	always_ff @(posedge MCLK or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			odd_reg <= 1'b0;
		end else if (c_take) begin
			odd_reg <= !c_odd;
		end
	end

	// Even pixel waits here for its odd partner
	always_ff @(posedge MCLK or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			e_first_reg <= 1'b0;
			e_y_reg     <= '0;
			e_u_reg     <= CHROMA_OFS;
			e_v_reg     <= CHROMA_OFS;
		end else if (c_take && !c_odd) begin
			e_first_reg <= c_first_reg;
			e_y_reg     <= c_y_reg;
			e_u_reg     <= c_u_reg; // R05
			e_v_reg     <= c_v_reg; // R05
		end
	end

	// Odd pixel completes a pair; its chroma is dropped
	assign f_in_valid = c_vld_reg & c_odd; // R05
	// Byte order is fixed per pair at push time
	always_comb begin
		unique case (fmt_reg)
			FMT_UYVY: f_in_data = {e_first_reg, e_u_reg, e_y_reg,
				e_v_reg, c_y_reg}; // R03 R06
			FMT_YUYV: f_in_data = {e_first_reg, e_y_reg, e_u_reg,
				c_y_reg, e_v_reg}; // R04 R06
		endcase
	end

	yuvpk_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk       (MCLK),
		.rst_n     (rst_n_sync),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (f_in_data),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	// Serializer: first byte of a word sits in the top lane
	assign load        = f_out_valid & (!BYTE_VALID | BYTE_READY);
	// Word leaves the FIFO together with its last byte
	assign f_out_ready = load & (idx_reg == LAST_IDX);

	always_comb begin
		unique case (idx_reg)
			2'h0: byte_sel = f_out_data[4*BYTE_W-1:3*BYTE_W];
			2'h1: byte_sel = f_out_data[3*BYTE_W-1:2*BYTE_W];
			2'h2: byte_sel = f_out_data[2*BYTE_W-1:BYTE_W];
			2'h3: byte_sel = f_out_data[BYTE_W-1:0];
		endcase
	end

	always_ff @(posedge MCLK or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			idx_reg <= '0;
		end else if (load) begin
			idx_reg <= idx_reg + 2'h1;
		end
	end

	// Byte offered until the sink takes it
	always_ff @(posedge MCLK or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			BYTE_VALID <= 1'b0;
		end else if (load) begin
			BYTE_VALID <= 1'b1;
		end else if (BYTE_READY) begin
			BYTE_VALID <= 1'b0;
		end
	end

	// Byte and its position flags, held while stalled
	always_ff @(posedge MCLK or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			BYTE_DATA  <= '0;
			BYTE_FIRST <= 1'b0;
			BYTE_LAST  <= 1'b0;
		end else if (load) begin
			BYTE_DATA  <= byte_sel; // R03 R04
			BYTE_FIRST <= f_out_data[WORD_W-1] & (idx_reg == 2'h0); // R09
			BYTE_LAST  <= (idx_reg == LAST_IDX);
		end
	end

endmodule // yuvpk_packer

// ---- yuvpk_packer_chk.sv ----
// Port checker for the 4:2:2 byte packer
`timescale 1ns/100ps
module yuvpk_chk
	import yuvpk_pkg::*;
(
	input wire logic              MCLK,
	input wire logic              RST_N,
	input wire logic              FMT_SEL,
	input wire logic              PIX_VALID,
	input wire logic              PIX_READY,
	input wire logic              PIX_FIRST,
	input wire logic [PIX_W-1:0]  PIX_RED,
	input wire logic [PIX_W-1:0]  PIX_GREEN,
	input wire logic [PIX_W-1:0]  PIX_BLUE,
	input wire logic              BYTE_VALID,
	input wire logic              BYTE_READY,
	input wire logic [BYTE_W-1:0] BYTE_DATA,
	input wire logic              BYTE_FIRST,
	input wire logic              BYTE_LAST
);
	int   pc;
	int   bc;
	logic tk;
	assign tk = BYTE_VALID && BYTE_READY;
	// Pixels taken and bytes taken since reset
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			pc <= 0;
			bc <= 0;
		end else begin
			pc <= pc + int'(PIX_VALID && PIX_READY);
			bc <= bc + int'(tk);
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	hold_valid_a: assert property (BYTE_VALID && !BYTE_READY |=> BYTE_VALID)
		else $error("byte withdrawn before taken");
	hold_data_a: assert property (BYTE_VALID && !BYTE_READY |=> $stable(BYTE_DATA))
		else $error("byte value changed while waiting");
	hold_flags_a: assert property (BYTE_VALID && !BYTE_READY
		|=> $stable({BYTE_FIRST, BYTE_LAST}))
		else $error("byte flags changed while waiting");
	last_pos_a: assert property (BYTE_VALID |-> BYTE_LAST == ((bc & 3) == 3))
		else $error("pair end flag off position");
	first_pos_a: assert property (BYTE_VALID && BYTE_FIRST |-> (bc & 3) == 0)
		else $error("line start flag not on pair start");
	pair_src_a: assert property (BYTE_VALID |-> pc >= 2 * (bc >> 2) + 2)
		else $error("byte sent before its pixel pair");
	pair_run_a: assert property (tk && !BYTE_LAST |=> BYTE_VALID)
		else $error("gap inside a pixel pair");
	full_stall_a: assert property (!PIX_READY |-> BYTE_VALID)
		else $error("pixel refused with output idle");
	cover property (BYTE_VALID && !BYTE_READY);
	cover property (!PIX_READY);
	cover property (tk && BYTE_FIRST);
endmodule // yuvpk_chk

bind yuvpk_packer yuvpk_chk i_chk (.MCLK(MCLK), .RST_N(RST_N),
	.FMT_SEL(FMT_SEL), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY),
	.PIX_FIRST(PIX_FIRST), .PIX_RED(PIX_RED), .PIX_GREEN(PIX_GREEN),
	.PIX_BLUE(PIX_BLUE), .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY),
	.BYTE_DATA(BYTE_DATA), .BYTE_FIRST(BYTE_FIRST), .BYTE_LAST(BYTE_LAST));

// ---- yuvpk_sink.sv ----
// Byte consumer standing in for the host image buffer
`timescale 1ns/100ps
module yuvpk_sink (
	input  wire logic       clk,
	input  wire logic [1:0] mode,
	output logic            ready
);
	initial ready = 1'b0;
	// Mode 0 takes all, 1 stalls at random, 2 holds off
	always @(posedge clk) begin
		case (mode)
			2'h0: ready <= 1'b1;
			2'h1: ready <= 1'($urandom_range(1));
			default: ready <= 1'b0;
		endcase
	end
endmodule // yuvpk_sink

// ---- yuvpk_packer_tb.sv ----
// Self-checking bench for the 4:2:2 byte packer
`timescale 1ns/100ps
module yuvpk_packer_tb;
	import yuvpk_pkg::*;
	logic       MCLK = 1'b0, RST_N = 1'b0, FMT_SEL = 1'b0;
	logic       PIX_VALID = 1'b0, PIX_FIRST = 1'b0;
	logic [7:0] PIX_RED = 8'h00, PIX_GREEN = 8'h00, PIX_BLUE = 8'h00;
	logic       PIX_READY, BYTE_VALID, BYTE_READY, BYTE_FIRST, BYTE_LAST;
	logic [7:0] BYTE_DATA;
	logic [1:0] mode = 2'h0;
	int         n_errors = 0, n_checks = 0, cyc = 0, fmt = 0;
	int         er, eg, eb, ef, have_ev = 0;
	logic [9:0] exp_q[$];
	logic [23:0] tbl[6] = '{24'hffffff, 24'h000000, 24'h0000ff,
		24'hff0000, 24'h808080, 24'h00ff00};

	yuvpk_packer i_dut (.MCLK(MCLK), .RST_N(RST_N), .FMT_SEL(FMT_SEL),
		.PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_FIRST(PIX_FIRST),
		.PIX_RED(PIX_RED), .PIX_GREEN(PIX_GREEN), .PIX_BLUE(PIX_BLUE),
		.BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY),
		.BYTE_DATA(BYTE_DATA), .BYTE_FIRST(BYTE_FIRST), .BYTE_LAST(BYTE_LAST));
	yuvpk_sink i_sink (.clk(MCLK), .mode(mode), .ready(BYTE_READY));

	initial forever #2 MCLK = ~MCLK;

	task automatic check(input logic [9:0] seen, input logic [9:0] want);
		n_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("ERROR %0t saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Reference: hold the even pixel, emit four bytes on the odd one
	task automatic model(input int r, g, b, f);
		int q[4];
		int y0, y1, u, v;
		if (f != 0 || have_ev == 0) begin
			er = r;
			eg = g;
			eb = b;
			ef = f;
			have_ev = 1;
			return;
		end
		y0 = (77 * er + 150 * eg + 29 * eb + 128) >> 8;
		y1 = (77 * r + 150 * g + 29 * b + 128) >> 8;
		u = ((-43 * er - 85 * eg + 128 * eb) >>> 8) + 128;
		v = ((128 * er - 107 * eg - 21 * eb) >>> 8) + 128;
		if (fmt != 0)
			q = '{y0, u, y1, v};
		else
			q = '{u, y0, v, y1};
		for (int i = 0; i < 4; i++)
			exp_q.push_back({1'(ef != 0 && i == 0), 1'(i == 3), 8'(q[i])});
		have_ev = 0;
	endtask

	task automatic put(input int r, g, b, f);
		@(posedge MCLK);
		PIX_VALID <= 1'b1;
		PIX_FIRST <= 1'(f);
		PIX_RED <= 8'(r);
		PIX_GREEN <= 8'(g);
		PIX_BLUE <= 8'(b);
		@(negedge MCLK);
		while (!PIX_READY) @(negedge MCLK);
		model(r, g, b, f);
	endtask

	task automatic line(input int n, input bit rnd);
		logic [23:0] p;
		for (int i = 0; i < n; i++) begin
			p = rnd ? 24'($urandom) : tbl[i % 6];
			put(p[23:16], p[15:8], p[7:0], int'(i == 0));
		end
		@(posedge MCLK);
		PIX_VALID <= 1'b0;
	endtask

	task automatic drain(input string name);
		int k;
		k = 0;
		while ((exp_q.size() != 0 || BYTE_VALID !== 1'b0) && k < 3000) begin
			@(negedge MCLK);
			k++;
		end
		check({9'(exp_q.size()), BYTE_VALID}, 10'h0);
		$display("test %s done", name);
	endtask

	always @(posedge MCLK) begin
		if (BYTE_VALID === 1'b1 && BYTE_READY === 1'b1)
			check({BYTE_FIRST, BYTE_LAST, BYTE_DATA},
				exp_q.size() != 0 ? exp_q.pop_front() : 10'hx);
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			complete_run();
		end
	end

	initial begin
		void'($urandom(32'h0125));
		repeat (3) @(posedge MCLK);
		RST_N <= 1'b1;
		repeat (6) @(posedge MCLK);
		mode <= 2'h1;
		line(8, 1);
		drain("uyvy random");
		@(posedge MCLK);
		FMT_SEL <= 1'b1;
		fmt = 1;
		mode <= 2'h0;
		repeat (8) @(posedge MCLK);
		line(6, 0);
		drain("yuyv extremes");
		mode <= 2'h2;
		fork
			line(32, 1);
			begin
				repeat (60) @(posedge MCLK);
				@(negedge MCLK);
				check({9'h0, PIX_READY}, 10'h0);
				mode <= 2'h1;
			end
		join
		drain("fill and drain");
		line(3, 1);
		line(4, 1);
		drain("odd line");
		complete_run();
	end
endmodule // yuvpk_packer_tb
